// [rtl/slch_defs.vh]
/*
 * constants for the secure login command handler: command codes, request
 * flag bits, state codes, error codes and response timing.
 * assumes it is included by bare name from design files under rtl/.
 */
`ifndef SLCH_DEFS_VH
`define SLCH_DEFS_VH

// ****************************************
// command codes
// ****************************************
`define SLCH_CMD_LOGIN        8'hE4
`define SLCH_CMD_FAST_RDMULT  8'hC3
`define SLCH_CMD_RDMULT       8'h23

// ****************************************
// request flag bits
// ****************************************
`define SLCH_FLAG_ADDRESS     5
`define SLCH_FLAG_SELECT      4

// ****************************************
// error codes
// ****************************************
`define SLCH_ERR_LOGIN        8'h0F
`define SLCH_ERR_UNSUPPORTED  8'h01

// ****************************************
// device states (one-hot)
// ****************************************
`define SLCH_ST_READY         3'h1
`define SLCH_ST_SELECTED      3'h2
`define SLCH_ST_QUIET         3'h4

// ****************************************
// response rate codes
// ****************************************
`define SLCH_RATE_STD         1'h0
`define SLCH_RATE_FAST        1'h1

// ****************************************
// timing
// ****************************************
`define SLCH_CLK_MHZ          100
`define SLCH_T_COMPARE_NS     40
`define SLCH_COMPARE_CYCLES   ((`SLCH_T_COMPARE_NS * `SLCH_CLK_MHZ + 999) / 1000)

`endif

// [rtl/slch_pw_compare.v]
/*
 * constant-time password comparator: compares a supplied 32-bit password
 * with the stored one and pulses done with the match result.
 * assumes start is a one-cycle pulse from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module slch_pw_compare #(
    parameter PW_WIDTH = 32,
    parameter CYCLES   = 4
) (
    input  wire                sys_clk,
    input  wire                reset,
    input  wire                start,
    input  wire [PW_WIDTH-1:0] supplied,
    input  wire [PW_WIDTH-1:0] stored,
    output reg                 done,
    output reg                 match
);

    // ****************************************
    // fixed-latency compare
    // ****************************************
    // the latency never depends on the data, so timing reveals nothing
    reg [7:0]          count;
    reg                busy;
    reg [PW_WIDTH-1:0] diff;

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count <= 8'h00;
            busy  <= 1'b0;
            diff  <= {PW_WIDTH{1'b0}};
            done  <= 1'b0;
            match <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy  <= 1'b1;
                count <= 8'h01;
                diff  <= supplied ^ stored;
            end else if (busy) begin
                if (count >= CYCLES[7:0]) begin
                    busy  <= 1'b0;
                    done  <= 1'b1;
                    match <= (diff == {PW_WIDTH{1'b0}});
                end else begin
                    count <= count + 8'h01;
                end
            end
        end
    end

endmodule // slch_pw_compare

`default_nettype wire

// [rtl/slch_handler.v]
/*
 * secure login command handler: decodes parsed requests, runs the login
 * password check, holds secure mode and the device state, and picks the
 * response data rate.
 * assumes an upstream frame decoder delivers one request per req_valid
 * pulse with fields already split and the crc verdict in req_crc_ok.
 */
`timescale 1ns/100ps
`default_nettype none
`include "slch_defs.vh"

// Functional notes
// - login request recognised by its command code with mfg code, optional uid, password.
// - login carries a 32-bit password; match with stored value enters secure mode.
// - password mismatch fails login, secure mode not granted, error code returned.
// - once secure, stay secure in all other cases, even after error responses.
// - state changes only on defined valid transitions; anything else leaves it unchanged.
// - unprocessable requests such as crc failures leave the current state untouched.
// - fast multiple-block read answers at fast rate, otherwise like standard read.
// - fast read carries flags, command, mfg code, optional uid, first block, count.

module slch_handler #(
    parameter PW_WIDTH = 32,
    parameter MFG_CODE = 8'h5A  // arbitrary value
) (
    input  wire                sys_clk,
    input  wire                reset,
    input  wire                req_valid,
    input  wire                req_crc_ok,
    input  wire [7:0]          req_flags,
    input  wire [7:0]          req_cmd,
    input  wire [7:0]          req_mfg,
    input  wire                req_uid_match,
    input  wire [PW_WIDTH-1:0] req_password,
    input  wire [7:0]          req_first_block,
    input  wire [7:0]          req_block_count,
    input  wire                req_select_hit,
    input  wire                req_quiet_hit,
    input  wire                req_reset_ready,
    input  wire [PW_WIDTH-1:0] stored_password,
    output reg                 secure_mode,
    output reg  [2:0]          dev_state,
    output reg                 rsp_valid,
    output reg                 rsp_error,
    output reg  [7:0]          rsp_error_code,
    output reg                 rsp_rate,
    output reg                 rd_start,
    output reg  [7:0]          rd_first_block,
    output reg  [7:0]          rd_block_count
);

    // ****************************************
    // state codes (one-hot)
    // ****************************************
    localparam [2:0] ST_READY    = `SLCH_ST_READY;
    localparam [2:0] ST_SELECTED = `SLCH_ST_SELECTED;
    localparam [2:0] ST_QUIET    = `SLCH_ST_QUIET;

    // ****************************************
    // request decode
    // ****************************************
    function addressed_ok;
        input [7:0] flags;
        input       uid_match;
        input [2:0] state;
        begin
            if (flags[`SLCH_FLAG_SELECT])
                addressed_ok = (state == ST_SELECTED);
            else if (flags[`SLCH_FLAG_ADDRESS])
                addressed_ok = uid_match;
            else
                addressed_ok = (state != ST_QUIET);
        end
    endfunction

    // command match for a request that passed crc, maker and addressing checks
    function cmd_hit;
        input       mine;
        input [7:0] cmd;
        input [7:0] code;
        begin
            cmd_hit = mine && (cmd == code);
        end
    endfunction

    // a failed crc makes the request invisible to every later stage
    wire take = req_valid && req_crc_ok;
    wire for_me = take && (req_mfg == MFG_CODE) &&
                  addressed_ok(req_flags, req_uid_match, dev_state);
    wire is_login  = cmd_hit(for_me, req_cmd, `SLCH_CMD_LOGIN);
    wire is_fast   = cmd_hit(for_me, req_cmd, `SLCH_CMD_FAST_RDMULT);
    wire is_rdmult = cmd_hit(for_me, req_cmd, `SLCH_CMD_RDMULT);

    // ****************************************
    // password compare
    // ****************************************
    localparam CMP_CYCLES = `SLCH_COMPARE_CYCLES;

    reg                pending;
    wire               cmp_done;
    wire               cmp_match;

    slch_pw_compare #(
        .PW_WIDTH (PW_WIDTH),
        .CYCLES   (CMP_CYCLES)
    ) u_cmp (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .start    (is_login && !pending),
        .supplied (req_password),
        .stored   (stored_password),
        .done     (cmp_done),
        .match    (cmp_match)
    );

    // ****************************************
    // state machine
    // ****************************************
    reg [2:0] next_state;

    always @* begin
        next_state = dev_state;
        if (take) begin
            case (dev_state)
                ST_READY: begin
                    if (req_select_hit)
                        next_state = ST_SELECTED;
                    else if (req_quiet_hit)
                        next_state = ST_QUIET;
                end
                ST_SELECTED: begin
                    if (req_reset_ready)
                        next_state = ST_READY;
                    else if (req_quiet_hit)
                        next_state = ST_QUIET;
                end
                ST_QUIET: begin
                    if (req_select_hit)
                        next_state = ST_SELECTED;
                    else if (req_reset_ready)
                        next_state = ST_READY;
                end
                default: next_state = dev_state;
            endcase
        end
    end

    // ****************************************
    // device state
    // ****************************************
    // transitions come only from next_state; idle or bad requests hold it
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dev_state <= ST_READY;
        end else begin
            dev_state <= next_state;
        end
    end

    // ****************************************
    // login in flight
    // ****************************************
    // a second login while one is pending is dropped, never queued
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pending <= 1'b0;
        end else if (cmp_done) begin
            pending <= 1'b0;
        end else if (is_login) begin
            pending <= 1'b1;
        end
    end

    // ****************************************
    // login answer and secure mode
    // ****************************************
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            secure_mode    <= 1'b0;
            rsp_valid      <= 1'b0;
            rsp_error      <= 1'b0;
            rsp_error_code <= 8'h00;
        end else begin
            rsp_valid <= cmp_done;
            if (cmp_done && cmp_match) begin
                secure_mode    <= 1'b1;
                rsp_error      <= 1'b0;
                rsp_error_code <= 8'h00;
            end else if (cmp_done) begin
                // failure only reports; a prior secure session stays
                rsp_error      <= 1'b1;
                rsp_error_code <= `SLCH_ERR_LOGIN;
            end
            // secure_mode has no other clearing path except reset
        end
    end

    // ****************************************
    // multiple-block read start
    // ****************************************
    // a login answer in the same cycle wins; the read is dropped, not queued
    wire rd_go = (is_fast || is_rdmult) && !cmp_done;

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_start       <= 1'b0;
            rd_first_block <= 8'h00;
            rd_block_count <= 8'h00;
        end else begin
            rd_start <= rd_go;
            if (rd_go) begin
                rd_first_block <= req_first_block;
                rd_block_count <= req_block_count;
            end
        end
    end

    // ****************************************
    // response data rate
    // ****************************************
    // the fast rate applies only to the fast read; every other answer is standard
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rsp_rate <= `SLCH_RATE_STD;
        end else if (cmp_done || is_rdmult) begin
            rsp_rate <= `SLCH_RATE_STD;
        end else if (is_fast) begin
            rsp_rate <= `SLCH_RATE_FAST;
        end
    end

endmodule // slch_handler

`default_nettype wire

// [dv/slch_handler_props.sv]
/* assertions on the ports of the login command handler.
   assumes one clock and an asynchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module slch_props (
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic       req_valid,
    input wire logic       req_crc_ok,
    input wire logic [7:0] req_flags,
    input wire logic [7:0] req_cmd,
    input wire logic [7:0] req_mfg,
    input wire logic [7:0] rsp_error_code,
    input wire logic       secure_mode,
    input wire logic       rsp_valid,
    input wire logic       rsp_error,
    input wire logic       rsp_rate,
    input wire logic       rd_start,
    input wire logic [2:0] dev_state
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // taken request: good crc, our maker code, unaddressed, not quiet
    wire tk = req_valid && req_crc_ok && req_mfg == 8'h5A && req_flags[5:4] == 2'h0
              && dev_state != 3'h4;
    property p_login_rsp; tk && req_cmd == 8'hE4 |-> ##[5:6] rsp_valid; endproperty
    a_login_rsp: assert property (p_login_rsp) else $error("login not answered");
    property p_login_ok; rsp_valid && !rsp_error |-> ##[0:1] secure_mode; endproperty
    a_login_ok: assert property (p_login_ok) else $error("no secure after login");
    property p_login_err; rsp_valid && rsp_error |-> rsp_error_code == 8'h0F; endproperty
    a_login_err: assert property (p_login_err) else $error("bad error code");
    property p_grant;
        $rose(secure_mode) |-> rsp_valid && !rsp_error || $past(rsp_valid) && !$past(rsp_error);
    endproperty
    a_grant: assert property (p_grant) else $error("secure without good login");
    property p_keep; secure_mode |=> secure_mode; endproperty
    a_keep: assert property (p_keep) else $error("secure mode lost");
    property p_onehot; $onehot(dev_state); endproperty
    a_onehot: assert property (p_onehot) else $error("state not one-hot");
    property p_idle; !req_valid |=> $stable(dev_state); endproperty
    a_idle: assert property (p_idle) else $error("state moved with no request");
    property p_crc; req_valid && !req_crc_ok |=> $stable(dev_state); endproperty
    a_crc: assert property (p_crc) else $error("state moved on bad crc");
    property p_fast; tk && req_cmd == 8'hC3 |=> rsp_valid || rd_start && rsp_rate; endproperty
    a_fast: assert property (p_fast) else $error("fast read not fast");
    property p_std; tk && req_cmd == 8'h23 |=> rsp_valid || rd_start && !rsp_rate; endproperty
    a_std: assert property (p_std) else $error("standard read rate wrong");
    // reset must win even while it is asserted, so no disable here
    property p_por; disable iff (1'b0) reset |=> !secure_mode; endproperty
    a_por: assert property (p_por) else $error("secure survives reset");
    c_ok: cover property (rsp_valid && !rsp_error);
    c_err: cover property (rsp_valid && rsp_error);
    c_fast: cover property (rd_start && rsp_rate);
endmodule // slch_props
bind slch_handler slch_props u_props (.sys_clk, .reset, .req_valid, .req_crc_ok, .req_flags,
    .req_cmd, .req_mfg, .rsp_error_code, .secure_mode, .rsp_valid, .rsp_error, .rsp_rate,
    .rd_start, .dev_state);
`default_nettype wire

// [dv/slch_reader_model.sv]
/* reader-side model: drives one parsed request per call of send.
   assumes the bench calls send from one process at a time. */
`timescale 1ns/100ps
`default_nettype none
module slch_reader_model #(
    parameter logic [7:0] MFG_CODE = 8'h5A  // arbitrary value
) (
    input  wire logic        sys_clk,
    output var  logic        req_valid,
    output var  logic        req_crc_ok,
    output var  logic [7:0]  req_flags,
    output var  logic [7:0]  req_cmd,
    output var  logic [7:0]  req_mfg,
    output var  logic        req_uid_match,
    output var  logic [31:0] req_password,
    output var  logic [7:0]  req_first_block,
    output var  logic [7:0]  req_block_count,
    output var  logic [2:0]  req_hits
);
    initial {req_valid, req_crc_ok, req_flags, req_cmd, req_mfg, req_uid_match} = '0;
    initial {req_password, req_first_block, req_block_count, req_hits} = '0;
    // fields other than flags and uid match are inverted between frames so a stale value never looks valid
    task automatic send(input logic [7:0] cmd, input logic crc, input logic [31:0] pw,
                        input logic [2:0] hits, input logic [15:0] blk,
                        input logic [7:0] flg);
        @(posedge sys_clk);
        req_valid <= 1'h1;
        req_crc_ok <= crc;
        {req_flags, req_cmd, req_mfg, req_uid_match} <= {flg, cmd, MFG_CODE, 1'h1};
        req_password <= pw;
        req_hits <= hits;
        {req_first_block, req_block_count} <= blk;
        @(posedge sys_clk);
        req_valid <= 1'h0;
        {req_crc_ok, req_cmd, req_mfg, req_password} <= ~{crc, cmd, MFG_CODE, pw};
        {req_hits, req_first_block, req_block_count} <= ~{hits, blk};
    endtask
endmodule // slch_reader_model
`default_nettype wire

// [dv/slch_handler_tb_top.sv]
/* self-checking bench for the login command handler.
   assumes the reader model and the bound checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module slch_handler_tb_top;
    logic        sys_clk, reset, req_valid, req_crc_ok, req_uid_match, seen;
    logic [7:0]  req_flags, req_cmd, req_mfg, req_first_block, req_block_count;
    logic [7:0]  rsp_error_code, rd_first_block, rd_block_count;
    logic [31:0] req_password, stored_password, rnd;
    logic [2:0]  dev_state, req_hits, exp_st, hits;
    logic [15:0] blk;
    logic        secure_mode, rsp_valid, rsp_error, rsp_rate, rd_start;
    int          err_total, n_tests, cyc;

    slch_handler DUT (.sys_clk, .reset, .req_valid, .req_crc_ok, .req_flags, .req_cmd,
        .req_mfg, .req_uid_match, .req_password, .req_first_block, .req_block_count,
        .req_select_hit(req_hits[2]), .req_quiet_hit(req_hits[1]),
        .req_reset_ready(req_hits[0]), .stored_password, .secure_mode, .dev_state,
        .rsp_valid, .rsp_error, .rsp_error_code, .rsp_rate, .rd_start, .rd_first_block,
        .rd_block_count);
    slch_reader_model u_reader (.sys_clk, .req_valid, .req_crc_ok, .req_flags, .req_cmd,
        .req_mfg, .req_uid_match, .req_password, .req_first_block, .req_block_count,
        .req_hits);

    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // hits are {select, quiet, reset to ready}
    function automatic logic [2:0] next_st(input logic [2:0] s, input logic [2:0] h);
        return h[2] ? 3'h2 : h[1] ? 3'h4 : h[0] ? 3'h1 : s;
    endfunction
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'h1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic print_verdict;
        if (err_total == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // waits a bounded time for the answer, then one cycle more for secure mode to settle
    task automatic login(input logic [31:0] pw, input logic crc);
        u_reader.send(8'hE4, crc, pw, 3'h0, 16'h0000, 8'h00);
        seen = 1'h0;
        for (int i = 0; i < 10 && !seen; i++) begin
            @(posedge sys_clk);
            #1 seen = (rsp_valid === 1'h1);
        end
        @(posedge sys_clk);
        #1;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_total++;
            $display("[FAIL] %0t timeout", $time);
            print_verdict();
        end
    end

    initial begin
        {cyc, err_total, n_tests} = '0;
        rnd = 32'h6DC83451;
        stored_password = lfsr(rnd);
        reset = 1'h1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'h0;
        @(posedge sys_clk);
        #1 chk(secure_mode === 1'h0 && dev_state === 3'h1, "reset values");
        login(~stored_password, 1'h1);
        chk(seen && rsp_error === 1'h1 && rsp_error_code === 8'h0F, "bad pw answer");
        chk(secure_mode === 1'h0, "secure on bad pw");
        login(stored_password, 1'h0);
        chk(!seen && secure_mode === 1'h0, "bad crc login acted");
        login(stored_password, 1'h1);
        chk(seen && rsp_error === 1'h0 && secure_mode === 1'h1, "login refused");
        login(stored_password ^ 32'h80000000, 1'h1);
        chk(seen && rsp_error_code === 8'h0F && secure_mode === 1'h1, "secure lost");
        exp_st = 3'h1;
        for (int k = 0; k < 7; k++) begin
            hits = 3'h1 << (k % 3);
            u_reader.send(8'h25, k != 4, rnd, hits, 16'h0000, 8'h00);
            @(posedge sys_clk);
            if (k != 4) exp_st = next_st(exp_st, hits);
            #1 chk(dev_state === exp_st, "state step");
        end
        for (int k = 0; k < 24; k++) begin
            rnd = lfsr(rnd);
            blk = (k == 0) ? 16'h00FF : rnd[15:0];
            // address flag drawn at random; the model always reports a uid match
            u_reader.send(rnd[31] ? 8'hC3 : 8'h23, 1'h1, rnd, 3'h0, blk, {2'h0, rnd[28], 5'h00});
            #1 chk(rd_start === 1'h1 && rsp_rate === rnd[31] &&
                   {rd_first_block, rd_block_count} === blk, "read answer");
        end
        chk(secure_mode === 1'h1, "secure lost late");
        // select flag: refused while ready, taken once selected
        u_reader.send(8'hC3, 1'h1, rnd, 3'h0, 16'h0102, 8'h10);
        #1 chk(rd_start === 1'h0, "select read taken while ready");
        u_reader.send(8'h25, 1'h1, rnd, 3'h4, 16'h0000, 8'h00);
        u_reader.send(8'hC3, 1'h1, rnd, 3'h0, 16'h0304, 8'h10);
        #1 chk(rd_start === 1'h1 && rsp_rate === 1'h1 && dev_state === 3'h2 &&
               {rd_first_block, rd_block_count} === 16'h0304, "select read refused");
        // mid-run reset while secure: the new session must start non-secure
        @(posedge sys_clk);
        reset <= 1'h1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'h0;
        @(posedge sys_clk);
        #1 chk(secure_mode === 1'h0 && dev_state === 3'h1, "secure kept over reset");
        print_verdict();
    end
endmodule // slch_handler_tb_top
`default_nettype wire
